// File: bench/lvdc_analog.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Comparator model
// ------------------------------------------------------------
module lvdc_analog #(
    parameter int SETTLE = 400
) (
    input wire logic pclk,
    input wire logic detect_enable,
    input wire logic level_select_bit,
    input wire logic [12:0] supply_mv,
    input wire logic [12:0] ext_mv,
    output logic supply_cmp_below,
    output logic ext_cmp_below
);
    int cnt = 32'h0;
    logic [12:0] th;
    // Before settling the output drifts, so software that reads early sees junk.
    always @(posedge pclk) cnt <= !detect_enable ? 32'h0 : (cnt < SETTLE ? cnt + 1 : cnt);
    assign th = level_select_bit ? 13'h0FFA : 13'h1090;
    assign supply_cmp_below = detect_enable && (cnt < SETTLE ? cnt[3] : supply_mv < th);
    assign ext_cmp_below = detect_enable && (cnt < SETTLE ? cnt[3] : ext_mv < 13'h04BA);
endmodule // lvdc_analog
`default_nettype wire

// File: bench/lvdc_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "lvdc_defines.vh"
// ------------------------------------------------------------
// Port checks for the detector control
// ------------------------------------------------------------
module lvdc_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`LVDC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic supply_cmp_below,
    input wire logic ext_cmp_below,
    input wire logic detect_enable,
    input wire logic level_select_bit,
    input wire logic detect_source_select,
    input wire logic detect_reset_req,
    input wire logic detect_irq
);
    logic mode_ff;
    logic wr;
    logic cur;
    assign wr = psel && penable && pwrite;
    assign cur = detect_source_select ? ext_cmp_below : supply_cmp_below;
    // Mode is no port, so it is shadowed from bus writes; full strobes assumed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mode_ff <= 1'b0;
        else if (wr && paddr == `LVDC_OFS_CTRL) mode_ff <= pwdata[1];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_cross;
        $changed(cur) && detect_enable && !mode_ff ##1
            ($stable(cur) && detect_enable && !mode_ff) [*2];
    endsequence
    AST_IRQ_EDGE: assert property (s_cross |-> ##[0:2] detect_irq)
        else $error("no interrupt after a crossing");
    AST_IRQ_PULSE: assert property (detect_irq |=> !detect_irq)
        else $error("interrupt pulse too long");
    AST_SYNC: assert property ($changed(cur) && detect_enable |-> !detect_irq ##1 !detect_irq)
        else $error("comparator reached logic too early");
    AST_QUIET: assert property (!detect_enable [*6] |-> !detect_irq && !detect_reset_req)
        else $error("activity while disabled");
    AST_RST_SET: assert property ((mode_ff && detect_enable && cur) [*6] |-> detect_reset_req)
        else $error("no reset while below");
    AST_RST_FREE: assert property (!cur [*5] |-> !detect_reset_req)
        else $error("reset while above level");
    AST_RST_HOLD: assert property (detect_reset_req && cur && detect_enable |=> detect_reset_req)
        else $error("reset dropped while below");
    AST_RST_IRQ_MODE: assert property (!mode_ff [*3] |-> !detect_reset_req)
        else $error("reset in interrupt mode");
    AST_LEVEL_OUT: assert property (wr && paddr == `LVDC_OFS_LEVEL |=> level_select_bit == $past(pwdata[0]))
        else $error("level select not applied");
endmodule // lvdc_properties
bind lvdc_top lvdc_properties lvdc_properties_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .supply_cmp_below(supply_cmp_below), .ext_cmp_below(ext_cmp_below),
    .detect_enable(detect_enable), .level_select_bit(level_select_bit),
    .detect_source_select(detect_source_select), .detect_reset_req(detect_reset_req),
    .detect_irq(detect_irq));
`default_nettype wire

// File: bench/tb_low_voltage_detect_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "lvdc_defines.vh"
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module tb_low_voltage_detect_control;
    localparam logic [11:0] A_CTRL = `LVDC_OFS_CTRL;
    localparam logic [11:0] A_MASK = `LVDC_OFS_MASK;
    localparam logic [11:0] A_IRQ = `LVDC_OFS_IRQ_FLAG;
    localparam logic [11:0] A_CAUSE = `LVDC_OFS_CAUSE;
    localparam int SETTLE = `LVDC_STAB_CYC + 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [12:0] supply_mv = 13'h1036;
    logic [12:0] ext_mv = 13'h0514;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, sup_b, ext_b, en, lvl, src, rst_req, irq, pend;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    always #12.5 pclk = ~pclk;
    lvdc_top lvdc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .supply_cmp_below(sup_b), .ext_cmp_below(ext_b),
        .detect_enable(en), .level_select_bit(lvl), .detect_source_select(src),
        .detect_reset_req(rst_req), .detect_irq(irq), .detect_irq_pending(pend));
    lvdc_analog #(.SETTLE(`LVDC_STAB_CYC)) lvdc_analog_inst (.pclk(pclk), .detect_enable(en),
        .level_select_bit(lvl), .supply_mv(supply_mv), .ext_mv(ext_mv),
        .supply_cmp_below(sup_b), .ext_cmp_below(ext_b));
    task automatic finish_test();
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // The idle edge after each transfer keeps two calls from driving psel in one step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    task automatic t_defaults();
        rdc("ctrl", A_CTRL, 32'h0);
        rdc("level", `LVDC_OFS_LEVEL, 32'h0);
        rdc("mask", A_MASK, 32'h1);
        rdc("cause", A_CAUSE, 32'h0);
        rdc("irq flag", A_IRQ, 32'h0);
        rdc("unmapped", 12'h014, 32'h0);
        chk("slverr", 32'h1, 32'(er));
    endtask
    task automatic t_irq_mode();
        apb(1'b1, A_MASK, 32'h1);
        apb(1'b1, `LVDC_OFS_LEVEL, 32'h1);
        apb(1'b1, A_CTRL, 32'h81);
        wt(SETTLE);
        rdc("ctrl above", A_CTRL, 32'hC0);
        apb(1'b1, A_IRQ, 32'h1);
        rdc("irq clear", A_IRQ, 32'h0);
        apb(1'b1, A_MASK, 32'h0);
        supply_mv <= 13'h0FA0;
        wt(6);
        rdc("ctrl below", A_CTRL, 32'hC1);
        rdc("irq fall", A_IRQ, 32'h1);
        chk("pending", 32'h1, 32'(pend));
        apb(1'b1, A_IRQ, 32'h1);
        supply_mv <= 13'h1036;
        wt(6);
        rdc("irq rise", A_IRQ, 32'h1);
        supply_mv <= 13'h0FA0;
        wt(6);
        apb(1'b1, A_IRQ, 32'h1);
        apb(1'b1, A_CTRL, 32'h0);
        wt(4);
        rdc("irq disable", A_IRQ, 32'h1);
        rdc("ctrl off", A_CTRL, 32'h0);
    endtask
    task automatic t_reset_mode();
        supply_mv <= 13'h1036;
        apb(1'b1, A_MASK, 32'h1);
        apb(1'b1, A_CTRL, 32'h80);
        wt(SETTLE);
        rdc("ctrl armed", A_CTRL, 32'hC0);
        apb(1'b1, A_CTRL, 32'h82);
        apb(1'b1, A_MASK, 32'h0);
        wt(6);
        chk("no reset above", 32'h0, 32'(rst_req));
        supply_mv <= 13'h0FA0;
        wt(6);
        chk("reset below", 32'h1, 32'(rst_req));
        rdc("cause", A_CAUSE, 32'h1);
        rdc("mask forced", A_MASK, 32'h1);
        rdc("ctrl kept", A_CTRL, 32'hC3);
        supply_mv <= 13'h1036;
        wt(6);
        chk("reset release", 32'h0, 32'(rst_req));
        apb(1'b1, A_CAUSE, 32'h1);
        rdc("cause clear", A_CAUSE, 32'h0);
        apb(1'b1, A_CTRL, 32'h80);
        apb(1'b1, A_CTRL, 32'h0);
    endtask
    task automatic t_ext_pin();
        apb(1'b1, A_CTRL, 32'h84);
        wt(SETTLE);
        rdc("pin armed", A_CTRL, 32'hC4);
        apb(1'b1, A_CTRL, 32'h86);
        ext_mv <= 13'h044C;
        wt(6);
        chk("pin reset", 32'h1, 32'(rst_req));
        chk("pin enable", 32'h1, 32'(en));
        chk("pin source", 32'h1, 32'(src));
        presetn <= 1'b0;
        wt(2);
        presetn <= 1'b1;
        rdc("ctrl sys reset", A_CTRL, 32'h0);
        rdc("level sys reset", `LVDC_OFS_LEVEL, 32'h0);
        rdc("cause sys reset", A_CAUSE, 32'h0);
        chk("enable sys reset", 32'h0, 32'(en));
        chk("source sys reset", 32'h0, 32'(src));
        rdc("mask sys reset", A_MASK, 32'h1);
    endtask
    initial begin
        wt(10);
        presetn <= 1'b1;
        t_defaults();
        t_irq_mode();
        t_reset_mode();
        t_ext_pin();
        finish_test();
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
endmodule // tb_low_voltage_detect_control
`default_nettype wire

// File: hdl/lvdc_defines.vh
`ifndef LVDC_DEFINES_VH
`define LVDC_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define LVDC_ADDR_W          12
`define LVDC_OFS_CTRL        12'h000
`define LVDC_OFS_LEVEL       12'h004
`define LVDC_OFS_MASK        12'h008
`define LVDC_OFS_IRQ_FLAG    12'h00C
`define LVDC_OFS_CAUSE       12'h010

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LVDC_CTRL_BELOW_BIT  0
`define LVDC_CTRL_MODE_BIT   1
`define LVDC_CTRL_SRC_BIT    2
`define LVDC_CTRL_READY_BIT  6
`define LVDC_CTRL_EN_BIT     7
`define LVDC_LEVEL_BIT       0
`define LVDC_MASK_BIT        0
`define LVDC_IRQ_FLAG_BIT    0
`define LVDC_CAUSE_BIT       0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LVDC_RST_EN          1'b0
`define LVDC_RST_MODE        1'b0
`define LVDC_RST_SRC         1'b0
`define LVDC_RST_LEVEL       1'b0
`define LVDC_RST_MASK        1'b1
`define LVDC_RST_IRQ_FLAG    1'b0
`define LVDC_RST_CAUSE       1'b0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LVDC_CLK_KHZ         40000
`define LVDC_STAB_NS         10000
`define LVDC_STAB_CYC        ((`LVDC_STAB_NS * `LVDC_CLK_KHZ + 999999) / 1000000)
`define LVDC_STAB_W          9

`endif

// File: hdl/lvdc_sync.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Two-stage level synchroniser, one chain per bit
// ----------------------------------------------------------------------------
module lvdc_sync #(
    parameter WIDTH = 2
) (
    input wire pclk,
    input wire presetn,
    input wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_ff;
            reg sync_ff;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                end else begin
                    meta_ff <= d[i];
                    sync_ff <= meta_ff;
                end
            end
            assign q[i] = sync_ff;
        end
    endgenerate

endmodule // lvdc_sync

`default_nettype wire

// File: hdl/lvdc_top.v
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lvdc_defines.vh"

// What this block does
// - Switching to reset mode while voltage is above level gives no reset.
// - Every reset, the detector's own included, sets the interrupt mask.
// - A reset caused by the detector is recorded in a readable cause flag.
// - In interrupt mode a level crossing raises the request and sets its flag.
// - In interrupt mode, clearing enable while below level raises the request and sets its flag.
// - Mode and source select both reset to zero: interrupt mode on supply.
// - On the supply, the threshold follows the level select bit.
// - Control bit 0 is a read-only flag showing voltage below level.
// - Interrupt requests fire on both falling below and returning above level.
// - Reset mode holds internal reset while below level, releases when above.
// - Enable, mode and source clear on system reset, kept on detector reset.
module lvdc_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`LVDC_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire supply_cmp_below,
    input wire ext_cmp_below,
    output wire detect_enable,
    output wire level_select_bit,
    output wire detect_source_select,
    output reg detect_reset_req,
    output reg detect_irq,
    output wire detect_irq_pending
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg en_ff;
    reg mode_ff;
    reg src_ff;
    reg level_ff;
    reg mask_ff;
    reg irq_flag_ff;
    reg cause_ff;
    reg below_ff;
    reg [`LVDC_STAB_W-1:0] stab_cnt_ff;
    wire [1:0] cmp_sync;
    wire below_now;
    wire irq_event;
    wire settled;

    // ------------------------------------------------------------------------
    // Comparator crossing
    // ------------------------------------------------------------------------
    lvdc_sync #(
        .WIDTH(2)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({ext_cmp_below, supply_cmp_below}),
        .q(cmp_sync)
    );

    // Disabled detector reports above-level, so in interrupt mode a disable while below
    // looks like a return crossing and raises the request by itself.
    assign below_now = en_ff & (src_ff ? cmp_sync[1] : cmp_sync[0]);
    assign irq_event = (below_now ^ below_ff) & ~mode_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            below_ff <= 1'b0;
            detect_irq <= 1'b0;
            detect_reset_req <= 1'b0;
        end else begin
            below_ff <= below_now;
            detect_irq <= irq_event;
            detect_reset_req <= below_now & mode_ff;
        end
    end

    assign detect_enable = en_ff;
    assign detect_source_select = src_ff;
    assign level_select_bit = level_ff;
    assign detect_irq_pending = irq_flag_ff & ~mask_ff;

    // ------------------------------------------------------------------------
    // Stabilisation timer
    // ------------------------------------------------------------------------
    // The timer only informs software; the flag itself is never held back,
    // so firmware that ignores the status still sees the raw comparison.
    // The count is reckoned as an integer and cut to the counter width on purpose.
    localparam integer STAB_CYC_INT = `LVDC_STAB_CYC;
    localparam [`LVDC_STAB_W-1:0] STAB_CYC = STAB_CYC_INT[`LVDC_STAB_W-1:0];
    assign settled = (stab_cnt_ff == STAB_CYC);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stab_cnt_ff <= {`LVDC_STAB_W{1'b0}};
        end else if (!en_ff) begin
            stab_cnt_ff <= {`LVDC_STAB_W{1'b0}};
        end else if (!settled) begin
            stab_cnt_ff <= stab_cnt_ff + 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    wire wr_en;
    wire rd_setup;
    wire lane0;
    wire hit_ctrl;
    wire hit_level;
    wire hit_mask;
    wire hit_flag;
    wire hit_cause;
    wire mapped;

    assign hit_ctrl = (paddr == `LVDC_OFS_CTRL);
    assign hit_level = (paddr == `LVDC_OFS_LEVEL);
    assign hit_mask = (paddr == `LVDC_OFS_MASK);
    assign hit_flag = (paddr == `LVDC_OFS_IRQ_FLAG);
    assign hit_cause = (paddr == `LVDC_OFS_CAUSE);
    assign mapped = hit_ctrl | hit_level | hit_mask | hit_flag | hit_cause;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr_en = psel & penable & pwrite & mapped;
    assign lane0 = pstrb[0];
    assign rd_setup = psel & ~penable & ~pwrite;

    // Configuration bits sit outside the detector-reset path on purpose:
    // only presetn clears them, while the detector's own reset leaves them.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= `LVDC_RST_EN;
            mode_ff <= `LVDC_RST_MODE;
            src_ff <= `LVDC_RST_SRC;
            level_ff <= `LVDC_RST_LEVEL;
        end else if (wr_en && lane0) begin
            if (hit_ctrl) begin
                en_ff <= pwdata[`LVDC_CTRL_EN_BIT];
                mode_ff <= pwdata[`LVDC_CTRL_MODE_BIT];
                src_ff <= pwdata[`LVDC_CTRL_SRC_BIT];
            end else if (hit_level) begin
                level_ff <= pwdata[`LVDC_LEVEL_BIT];
            end
        end
    end

    // Mask is forced high by the detector's own reset as well as presetn.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= `LVDC_RST_MASK;
        end else if (detect_reset_req) begin
            mask_ff <= 1'b1;
        end else if (wr_en && lane0 && hit_mask) begin
            mask_ff <= pwdata[`LVDC_MASK_BIT];
        end
    end

    // Write-one-to-clear flags; a new event in the clearing cycle wins.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag_ff <= `LVDC_RST_IRQ_FLAG;
            cause_ff <= `LVDC_RST_CAUSE;
        end else begin
            if (irq_event) begin
                irq_flag_ff <= 1'b1;
            end else if (wr_en && lane0 && hit_flag && pwdata[`LVDC_IRQ_FLAG_BIT]) begin
                irq_flag_ff <= 1'b0;
            end
            if (detect_reset_req) begin
                cause_ff <= 1'b1;
            end else if (wr_en && lane0 && hit_cause && pwdata[`LVDC_CAUSE_BIT]) begin
                cause_ff <= 1'b0;
            end
        end
    end

    // Read data is captured in the setup cycle so it stands for the whole
    // zero-wait access phase.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= 32'h00000000;
            if (hit_ctrl) begin
                prdata[`LVDC_CTRL_EN_BIT] <= en_ff;
                prdata[`LVDC_CTRL_READY_BIT] <= settled;
                prdata[`LVDC_CTRL_SRC_BIT] <= src_ff;
                prdata[`LVDC_CTRL_MODE_BIT] <= mode_ff;
                prdata[`LVDC_CTRL_BELOW_BIT] <= below_now;
            end else if (hit_level) begin
                prdata[`LVDC_LEVEL_BIT] <= level_ff;
            end else if (hit_mask) begin
                prdata[`LVDC_MASK_BIT] <= mask_ff;
            end else if (hit_flag) begin
                prdata[`LVDC_IRQ_FLAG_BIT] <= irq_flag_ff;
            end else if (hit_cause) begin
                prdata[`LVDC_CAUSE_BIT] <= cause_ff;
            end
        end
    end

endmodule // lvdc_top

`default_nettype wire
